// *** logic/asro_pkg.sv ***
// Package with constants and types for the serial result output block
package asro_pkg;

    // ==========================================================
    // Word layout
    localparam int WORD_BITS      = 32;
    localparam int RESULT_BITS    = 24;
    localparam int SUB_BITS       = 5;
    localparam int EOC_POS        = 31;
    localparam int FILLER_POS     = 30;
    localparam int POLARITY_POS   = 29;
    localparam int RESULT_MSB_POS = 28;
    localparam int RESULT_LSB_POS = 5;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [11:0] CTRL_ADDR   = 12'h000;
    localparam logic [11:0] SAMPLE_ADDR = 12'h004;
    localparam logic [11:0] STATUS_ADDR = 12'h008;
    localparam logic [11:0] WORD_ADDR   = 12'h00C;
    localparam logic [11:0] COUNT_ADDR  = 12'h010;

    // CTRL fields
    localparam int CTRL_START_POS = 0;
    localparam int CTRL_DONE_POS  = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] SAMPLE_RESET = 32'h0000_0000;

    // STATUS fields
    localparam int ST_STATE_LSB   = 0;
    localparam int ST_EXTCLK_POS  = 2;
    localparam int ST_REJ50_POS   = 3;
    localparam int ST_EOC_POS     = 4;

    // ==========================================================
    // Timing
    localparam int CLK_HZ             = 100_000_000;
    localparam int EXT_CLK_MIN_HZ     = 2560;
    localparam int NOTCH_DIVIDE       = 2560;
    // Longest gap between external clock edges that still counts as present
    localparam int EXT_GAP_CYCLES     = CLK_HZ / EXT_CLK_MIN_HZ;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ASRO_CONVERT,
        ASRO_SLEEP,
        ASRO_OUTPUT
    } asro_state_t;

    typedef struct packed {
        logic        eoc;
        logic        filler_bit;
        logic        polarity_bit;
        logic [23:0] result;
        logic [4:0]  sub_lsb;
    } asro_word_t;

    typedef struct packed {
        logic        sign;
        logic        over;
        logic        under;
        logic [28:0] mag;
    } asro_sample_t;

endpackage

// *** logic/asro_top.sv ***
// Serial result output, conversion clock selection and AHB-Lite registers
// ==========================================================
`timescale 1ns/1ps

module asro_top (
    // System
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // Serial link pins
    input  wire logic                  select_n,
    input  wire logic                  serial_clk,
    output logic                       serial_result_out,
    output logic                       serial_result_oe_n,
    // Rejection select pin and conversion pacing
    input  wire logic                  rejection_select_pin,
    output logic                       conv_tick,
    output logic                       ext_clk_mode,
    output logic                       rej_50hz
);
    import asro_pkg::*;

    // ==========================================================
    // Reset release
    logic rst_meta_reg, rst_sync_reg;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire logic rst_ok = rst_sync_reg;

    // ==========================================================
    // Pin synchronisers (first stage read by second only)
    logic [2:0] pin_meta_reg, pin_sync_reg;
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            pin_meta_reg <= 3'b001;
            pin_sync_reg <= 3'b001;
        end else begin
            pin_meta_reg <= {rejection_select_pin, serial_clk, select_n};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    wire logic sel_n_s = pin_sync_reg[0];
    wire logic sck_s   = pin_sync_reg[1];
    wire logic rsp_s   = pin_sync_reg[2];

    logic sck_d_reg, rsp_d_reg;
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            sck_d_reg <= 1'b0;
            rsp_d_reg <= 1'b0;
        end else begin
            sck_d_reg <= sck_s;
            rsp_d_reg <= rsp_s;
        end
    end
    wire logic sck_rise = sck_s & ~sck_d_reg;
    wire logic sck_fall = ~sck_s & sck_d_reg;
    wire logic rsp_rise = rsp_s & ~rsp_d_reg;

    // ==========================================================
    // External conversion clock detection
    // Edges closer than one period of the slowest legal clock mean present
    // A lone rise (pin strapped high) is no clock: two rises within the gap are needed
    localparam int               GAP_W     = $clog2(EXT_GAP_CYCLES + 1);
    localparam logic [GAP_W-1:0] GAP_LIMIT = GAP_W'(EXT_GAP_CYCLES);
    logic [GAP_W-1:0] gap_cnt_reg;
    logic             ext_mode_reg;
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            gap_cnt_reg  <= GAP_LIMIT;
            ext_mode_reg <= 1'b0;
        end else if (rsp_rise) begin
            gap_cnt_reg  <= '0;
            if (gap_cnt_reg != GAP_LIMIT) begin
                ext_mode_reg <= 1'b1;
            end
        end else if (gap_cnt_reg == GAP_LIMIT) begin
            ext_mode_reg <= 1'b0;
        end else begin
            gap_cnt_reg <= gap_cnt_reg + 1'b1;
        end
    end

    // Notch pacing: one tick per 2560 external clocks
    logic [11:0] notch_cnt_reg;
    logic        conv_tick_reg;
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            notch_cnt_reg <= '0;
            conv_tick_reg <= 1'b0;
        end else begin
            conv_tick_reg <= 1'b0;
            if (ext_mode_reg && rsp_rise) begin
                if (notch_cnt_reg == 12'(NOTCH_DIVIDE - 1)) begin
                    notch_cnt_reg <= '0;
                    conv_tick_reg <= 1'b1;
                end else begin
                    notch_cnt_reg <= notch_cnt_reg + 1'b1;
                end
            end
        end
    end

    // Rejection level: taken only when the internal oscillator is in use
    logic rej50_reg;
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            rej50_reg <= 1'b0;
        end else if (!ext_mode_reg) begin
            rej50_reg <= rsp_s;
        end
    end

    // ==========================================================
    // Register file
    logic [31:0]  ctrl_reg;
    asro_sample_t sample_reg;
    logic         start_req;
    logic         done_req;
    logic [5:0]   bit_cnt_reg;
    asro_state_t  state_reg;
    logic [31:0]  shift_reg;

    logic        dp_write_reg;
    logic        dp_read_reg;
    logic [11:0] dp_addr_reg;
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            dp_write_reg <= 1'b0;
            dp_read_reg  <= 1'b0;
            dp_addr_reg  <= '0;
        end else if (hready) begin
            dp_write_reg <= hsel & htrans[1] & hwrite;
            dp_read_reg  <= hsel & htrans[1] & ~hwrite;
            dp_addr_reg  <= haddr[11:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            ctrl_reg   <= CTRL_RESET;
            sample_reg <= SAMPLE_RESET;
        end else if (dp_write_reg) begin
            case (dp_addr_reg)
                CTRL_ADDR:   ctrl_reg   <= hwdata;
                SAMPLE_ADDR: sample_reg <= hwdata;
                default:     ctrl_reg   <= ctrl_reg;
            endcase
        end else begin
            ctrl_reg <= ctrl_reg & ~32'h0000_0003;
        end
    end
    assign start_req = ctrl_reg[CTRL_START_POS];
    assign done_req  = ctrl_reg[CTRL_DONE_POS];

    // Read data registered on the address phase; zero wait states
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            hrdata <= '0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[11:0])
                CTRL_ADDR:   hrdata <= ctrl_reg;
                SAMPLE_ADDR: hrdata <= sample_reg;
                STATUS_ADDR: hrdata <= {27'h000_0000, state_reg == ASRO_CONVERT,
                                        rej50_reg, ext_mode_reg, state_reg};
                WORD_ADDR:   hrdata <= shift_reg;
                COUNT_ADDR:  hrdata <= {26'h000_0000, bit_cnt_reg};
                default:     hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ==========================================================
    // Result encoding
    function automatic asro_word_t encode(input asro_sample_t s, input logic eoc);
        asro_word_t w;
        w.eoc        = eoc;
        w.filler_bit = 1'b0;
        if (s.over) begin
            w.polarity_bit = 1'b1;
            {w.result, w.sub_lsb} = {1'b1, 28'h000_0000};
        end else if (s.under) begin
            w.polarity_bit = 1'b0;
            {w.result, w.sub_lsb} = {1'b0, 28'hFFF_FFFF};
        end else begin
            w.polarity_bit = ~s.sign;
            {w.result, w.sub_lsb} = s.mag;
        end
        return w;
    endfunction

    // ==========================================================
    // Converter cycle and shift register
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            state_reg   <= ASRO_CONVERT;
            shift_reg   <= '0;
            bit_cnt_reg <= '0;
        end else begin
            case (state_reg)
                ASRO_CONVERT: begin
                    bit_cnt_reg <= '0;
                    if (done_req) begin
                        shift_reg <= encode(sample_reg, 1'b0);
                        state_reg <= ASRO_SLEEP;
                    end
                end
                ASRO_SLEEP: begin
                    if (!sel_n_s && sck_fall) begin
                        shift_reg   <= {shift_reg[30:0], 1'b1};
                        bit_cnt_reg <= 6'd1;
                        state_reg   <= ASRO_OUTPUT;
                    end
                end
                ASRO_OUTPUT: begin
                    if (sel_n_s) begin
                        state_reg <= ASRO_CONVERT;
                    end else if (sck_fall) begin
                        shift_reg   <= {shift_reg[30:0], 1'b1};
                        bit_cnt_reg <= bit_cnt_reg + 1'b1;
                        if (bit_cnt_reg == 6'(WORD_BITS - 1)) begin
                            state_reg <= ASRO_CONVERT;
                        end
                    end
                end
                default: state_reg <= ASRO_CONVERT;
            endcase
        end
    end

    // ==========================================================
    // Serial output pin
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            serial_result_out  <= 1'b1;
            serial_result_oe_n <= 1'b1;
        end else begin
            serial_result_oe_n <= sel_n_s;
            if (state_reg == ASRO_CONVERT) begin
                serial_result_out <= 1'b1;
            end else begin
                serial_result_out <= shift_reg[EOC_POS];
            end
        end
    end

    // Start request registered to pulse conv_tick while external clock mode is off; conversion starts itself
    logic start_seen_reg;
    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            start_seen_reg <= 1'b0;
        end else begin
            start_seen_reg <= start_req;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_ok) begin
        if (!rst_ok) begin
            conv_tick    <= 1'b0;
            ext_clk_mode <= 1'b0;
            rej_50hz     <= 1'b0;
        end else begin
            conv_tick    <= conv_tick_reg | (start_seen_reg & ~ext_mode_reg);
            ext_clk_mode <= ext_mode_reg;
            rej_50hz     <= rej50_reg;
        end
    end

endmodule

// *** sim/asro_chk.sv ***
// Concurrent checks on the serial result output block ports
`timescale 1ns/1ps

module asro_chk (
    // System
    input wire logic clk_sys,
    input wire logic rst_n,
    // Serial link
    input wire logic select_n,
    input wire logic serial_clk,
    input wire logic serial_result_out,
    input wire logic serial_result_oe_n,
    // Conversion pacing
    input wire logic rejection_select_pin,
    input wire logic conv_tick,
    input wire logic ext_clk_mode,
    input wire logic rej_50hz
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Assertions
    a_float_deselected: assert property (select_n [*6] |-> serial_result_oe_n)
        else $error("serial output driven while deselected");
    a_release_on_high: assert property ($rose(select_n) |-> ##[1:6] serial_result_oe_n)
        else $error("serial output not released after select high");
    a_drive_on_low: assert property ($fell(select_n) |-> ##[1:6] !serial_result_oe_n)
        else $error("serial output not driven after select low");
    // Bit changes may only land while the host clock is low
    a_change_on_fall: assert property (!serial_result_oe_n && $past(!serial_result_oe_n)
        && $changed(serial_result_out) |-> !serial_clk)
        else $error("serial output changed while serial clock high");
    a_rej_high_50: assert property ((rejection_select_pin && !ext_clk_mode) [*8] |-> rej_50hz)
        else $error("pin high without 50Hz setting");
    a_rej_low_60: assert property ((!rejection_select_pin && !ext_clk_mode) [*8] |-> !rej_50hz)
        else $error("pin low without 60Hz setting");
    a_tick_pulse: assert property (conv_tick |=> !conv_tick)
        else $error("conversion tick longer than one cycle");
    a_ext_drop_idle: assert property ($fell(ext_clk_mode) |->
        $past(rejection_select_pin, 1) == $past(rejection_select_pin, 8))
        else $error("external mode dropped while pin toggling");

    // ==========================================================
    // Coverage
    c_ext_mode: cover property ($rose(ext_clk_mode));
    c_tick: cover property (conv_tick);
    c_eoc_fall: cover property ($fell(serial_result_out) && !serial_result_oe_n);
endmodule

// *** sim/asro_host_model.sv ***
// Host side model that polls and reads result words over the serial link
`timescale 1ns/1ps

module asro_host_model (
    // System
    input  wire logic clk_sys,
    // Serial link
    input  wire logic serial_result_out,
    input  wire logic serial_result_oe_n,
    output logic      select_n,
    output logic      serial_clk
);
    // Released line reads inverted so a stale bit never passes
    wire line = serial_result_oe_n ? ~serial_result_out : serial_result_out;

    initial begin
        select_n   = 1'b1;
        serial_clk = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic sel(input logic v);
        @(posedge clk_sys);
        select_n <= v;
    endtask

    // Clock idles low, so the first edge is a rise; the block shifts a bit only on the fall
    task automatic pulse(input int n);
        repeat (n) begin
            serial_clk <= 1'b1;
            wait_cyc(8);
            serial_clk <= 1'b0;
            wait_cyc(8);
        end
    endtask

    task automatic frame(input int nbits, output logic [31:0] w, output logic nxt);
        w = '0;
        sel(1'b0);
        wait_cyc(8);
        for (int i = 31; i > 31 - nbits; i--) begin
            serial_clk <= 1'b1;
            w[i] = line;
            wait_cyc(8);
            serial_clk <= 1'b0;
            wait_cyc(8);
        end
        nxt = line;
        sel(1'b1);
        wait_cyc(8);
    endtask
endmodule

// *** sim/adc_serial_result_output_test.sv ***
// Self-checking bench for the serial result output block
`timescale 1ns/1ps

module adc_serial_result_output_test;
    import asro_pkg::*;

    logic        clk_sys, rst_n, hsel, hwrite, hreadyout, hresp, rejection_select_pin;
    logic [31:0] haddr, hwdata, hrdata, q, w;
    logic [1:0]  htrans;
    logic        select_n, serial_clk, serial_result_out, serial_result_oe_n;
    logic        conv_tick, ext_clk_mode, rej_50hz, nxt;
    int          errors, comparisons, ticks, t0;
    logic [31:0] smp [6] = '{32'h0000_0000, 32'h9FFF_FFFF, 32'h9000_0000,
                             32'h4123_4567, 32'hA000_0001, 32'h0ABC_DEF5};
    logic [31:0] exw [6] = '{32'h2000_0000, 32'h1FFF_FFFF, 32'h1000_0000,
                             32'h3000_0000, 32'h0FFF_FFFF, 32'h2ABC_DEF5};

    asro_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .select_n(select_n), .serial_clk(serial_clk),
        .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n),
        .rejection_select_pin(rejection_select_pin), .conv_tick(conv_tick),
        .ext_clk_mode(ext_clk_mode), .rej_50hz(rej_50hz));
    asro_host_model host (.clk_sys(clk_sys), .serial_result_out(serial_result_out),
        .serial_result_oe_n(serial_result_oe_n), .select_n(select_n), .serial_clk(serial_clk));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (conv_tick === 1'b1) ticks <= ticks + 1;

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    // Single AHB-Lite transfer; waits on hready in both phases
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {20'h0_0000, a};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic t_word(input logic [31:0] s, input logic [31:0] e, input logic poll);
        if (poll) begin
            host.sel(1'b0);
            host.wait_cyc(10);
            chk("busy flag", 32'h1, serial_result_out);
        end
        ahb(1'b1, SAMPLE_ADDR, s);
        ahb(1'b1, CTRL_ADDR, 32'h0000_0002);
        if (poll) begin
            for (int k = 0; k < 12 && serial_result_out !== 1'b0; k++) @(posedge clk_sys);
            chk("eoc fall", 32'h0, serial_result_out);
        end else begin
            ahb(1'b0, STATUS_ADDR, 32'h0);
            chk("sleep state", 32'h1, q[1:0]);
        end
        host.frame(32, w, nxt);
        chk("word", e, w);
        chk("next eoc", 32'h1, nxt);
        ahb(1'b0, STATUS_ADDR, 32'h0);
        chk("convert after word", 32'h0, q[1:0]);
        $display("test word %h done", s);
    endtask

    task automatic t_abort();
        ahb(1'b1, SAMPLE_ADDR, 32'h0ABC_DEF5);
        ahb(1'b1, CTRL_ADDR, 32'h0000_0002);
        host.frame(5, w, nxt);
        chk("partial word", 32'h2800_0000, w);
        ahb(1'b0, STATUS_ADDR, 32'h0);
        chk("convert after abort", 32'h0, q[1:0]);
        host.pulse(4);
        chk("released", 32'h1, serial_result_oe_n);
        $display("test abort done");
    endtask

    task automatic ext_edges(input int n);
        repeat (2 * n) begin
            repeat (4) @(posedge clk_sys);
            rejection_select_pin <= ~rejection_select_pin;
        end
    endtask

    task automatic t_clock();
        repeat (12) @(posedge clk_sys);
        chk("60Hz", 32'h0, rej_50hz);
        rejection_select_pin <= 1'b1;
        repeat (12) @(posedge clk_sys);
        chk("50Hz", 32'h1, rej_50hz);
        t0 = ticks;
        ahb(1'b1, CTRL_ADDR, 32'h0000_0001);
        repeat (6) @(posedge clk_sys);
        chk("start tick", 32'h1, ticks - t0);
        ext_edges(64);
        chk("ext detect", 32'h1, ext_clk_mode);
        t0 = ticks;
        ext_edges(NOTCH_DIVIDE);
        chk("ext ticks", 32'h1, ticks - t0);
        repeat (EXT_GAP_CYCLES + 40) @(posedge clk_sys);
        chk("ext lost", 32'h0, ext_clk_mode);
        chk("50Hz after ext", 32'h1, rej_50hz);
        $display("test clock done");
    endtask

    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        {rst_n, hsel, hwrite, rejection_select_pin, htrans, haddr, hwdata} = '0;
        {errors, comparisons, ticks} = '0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk("oe after reset", 32'h1, serial_result_oe_n);
        ahb(1'b0, STATUS_ADDR, 32'h0);
        chk("status after reset", 32'h10, q[4:0]);
        chk("okay response", 32'h0, hresp);
        t_abort();
        for (int i = 0; i < 6; i++) t_word(smp[i], exw[i], i == 5);
        t_clock();
        summarize();
    end

    initial begin
        #900_000;
        errors++;
        summarize();
    end
endmodule

bind asro_top asro_chk u_chk (.*);
